// [rtl/ccd_cfg.svh]
// ccd_cfg.svh: constants of the compact instruction decoder
// Contract
// - register copy carries two full 5-bit register fields
// - stack word load/store offset is shifted left by two onto sp
// - same-register add uses one 5-bit register, 4-bit signed immediate
// - stack adjust decodes 9 bits to -258..-3, 2..257, times four, onto sp
// - two-register add maps 3 bits to -1,1,4,8,12,16,20,24
// - stack-relative address writes sp plus 6-bit immediate times four
// - no-op is a register copy from register zero to register zero
// - negate is a subtract with register zero as first source
// - branch offsets shift left one; unconditional form has 10 bits
// - conditional branches test one register against zero, 7-bit offset
// - jump without slot transfers control at once through 5-bit register
// - long-slot call expects 32-bit slot, short-slot call 16-bit slot
// - return form jumps through register and pops 5-bit times four
// - break and debug break carry a 4-bit code in one halfword
// - result-word reads copy high or low into any 5-bit register
// - 3-bit fields map to 16,17,2-7; store source and subtract minuend to 0,17,2-7
// - byte, half, word offsets scale by 1, 2, 4; byte load -1..14
// - AND mask list of sixteen values; small constant -1..126
// - length follows from the low 3 bits of the 6-bit major opcode alone
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH
// ----------------------------------------
// registers
// ----------------------------------------
`define CCD_CTRL     12'h000
`define CCD_STAT     12'h004
`define CCD_CTRL_RST 1'b1
`define CCD_ACC_W    12'h004
// ----------------------------------------
// major opcodes
// ----------------------------------------
`define MJ_P16A  6'h01
`define MJ_P16B  6'h09
`define MJ_P16C  6'h11
`define MJ_LWGP  6'h19
`define MJ_P16D  6'h13
`define MJ_P16E  6'h1B
`define MJ_LBU   6'h02
`define MJ_LHU   6'h0A
`define MJ_STACK_WORD_LOAD  6'h12
`define MJ_LW    6'h1A
`define MJ_SB    6'h22
`define MJ_SH    6'h2A
`define MJ_STACK_WORD_STORE  6'h32
`define MJ_SW    6'h3A
`define MJ_MOVE  6'h03
`define MJ_ANDI  6'h0B
`define MJ_B     6'h33
`define MJ_BEQZ  6'h23
`define MJ_BNEZ  6'h2B
`define MJ_LI    6'h3B
`define LEN16_LO 3'h1
`define LEN16_HI 3'h3
// ----------------------------------------
// minor opcodes of the register pool
// ----------------------------------------
`define MN_NOT   4'h0
`define MN_XOR   4'h1
`define MN_AND   4'h2
`define MN_OR    4'h3
`define MN_JR    5'h05
`define MN_JRC   5'h07
`define MN_JALR  5'h0D
`define MN_JALRS 5'h0F
`define MN_MFHI  5'h0E
`define MN_MFLO  5'h0C
`define MN_POP   5'h0B
`define MN_BRK   6'h1B
`define MN_DBG   6'h3B
// ----------------------------------------
// fields, registers, immediates
// ----------------------------------------
`define F_MAJ 15:10
`define F_MLO 12:10
`define F_A3  9:7
`define F_B3  6:4
`define F_C3  3:1
`define F_A5  9:5
`define F_B5  4:0
`define F_I4  3:0
`define F_I4H 4:1
`define F_I6  6:1
`define F_I7  6:0
`define F_I9  9:1
`define F_I10 9:0
`define F_C4  9:6
`define F_M6  5:0
`define F_LOG 3:2
`define F_SEL 0
`define F_ST  15
`define R_ZERO 5'h00
`define R_GP   5'h1C
`define R_SP   5'h1D
`define R_RA   5'h1F
`define SH_BR  1
`define SH_W   2
`define LBU_NEG 4'hF
`define LI_NEG  7'h7F
`define SA_ZERO 32'h00000008
`define ADJ_OFS 11'sh100
`define ADJ_LO  11'sh002
`define ADJ_HI  11'sh7FE
`endif

// [rtl/ccd_decoder.sv]
// ccd_decoder.sv: compact halfword instruction decoder with apb control
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "ccd_cfg.svh"
module ccd_decoder
   import ccd_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // fetch side
   input  wire logic        insn_valid,
   input  wire logic [15:0] insn_half,
   output logic             insn_ready,
   // execute side
   output ccd_dec_t         dec,
   output logic             dec_valid
);
   // ----------------------------------------
   // tables
   // ----------------------------------------
   localparam logic [15:0] AND_MASK [16] = '{16'h0001, 16'h0002, 16'h0003,
      16'h0004, 16'h0007, 16'h0008, 16'h000F, 16'h0010, 16'h001F, 16'h0020,
      16'h003F, 16'h0040, 16'h0080, 16'h00FF, 16'h8000, 16'hFFFF};
   localparam logic [31:0] R2_IMM [8] = '{32'hFFFFFFFF, 32'h00000001,
      32'h00000004, 32'h00000008, 32'h0000000C, 32'h00000010, 32'h00000014,
      32'h00000018};
   localparam logic [4:0] MAP3  [8] = '{5'h10, 5'h11, 5'h02, 5'h03, 5'h04,
      5'h05, 5'h06, 5'h07};
   localparam logic [4:0] MAP3Z [8] = '{5'h00, 5'h11, 5'h02, 5'h03, 5'h04,
      5'h05, 5'h06, 5'h07};
   ccd_dec_t          next_dec;
   logic              ctrl_en;
   logic [15:0]       rsvd_cnt;
   ccd_op_t           last_op;
   logic              take;
   logic              is16;
   logic              wr_acc;
   logic              mapped;
   logic signed [10:0] adj;
   assign is16 = (insn_half[`F_MLO] >= `LEN16_LO) &&
                 (insn_half[`F_MLO] <= `LEN16_HI);
   assign insn_ready = ctrl_en;
   assign take = insn_valid && ctrl_en;
   // ----------------------------------------
   // decode
   // ----------------------------------------
   always_comb
   begin
      next_dec = '0;
      next_dec.op = OP_RSVD;
      next_dec.size = SZ_W;
      adj = 11'($signed(insn_half[`F_I9]));
      if ((adj >= 11'sh000) && (adj < `ADJ_LO))
         adj = adj + `ADJ_OFS;
      else if ((adj < 11'sh000) && (adj >= `ADJ_HI))
         adj = adj - `ADJ_OFS;
      if (!is16)
      begin
         next_dec.op = OP_LONG;
         next_dec.is_long = 1'b1;
      end
      else
      begin
         case (insn_half[`F_MAJ])
            `MJ_MOVE:
            begin
               // nop is simply copy zero to zero, no opcode of its own
               next_dec.op = OP_ADD;
               next_dec.rd = insn_half[`F_A5];
               next_dec.rs = insn_half[`F_B5];
               next_dec.rt = `R_ZERO;
            end
            `MJ_P16A:
            begin
               next_dec.op = insn_half[`F_SEL] ? OP_SUB : OP_ADD;
               next_dec.rd = MAP3[insn_half[`F_A3]];
               next_dec.rt = MAP3[insn_half[`F_B3]];
               // subtract minuend may be zero so negate needs no opcode
               next_dec.rs = insn_half[`F_SEL] ? MAP3Z[insn_half[`F_C3]]
                                               : MAP3[insn_half[`F_C3]];
            end
            `MJ_P16B:
            begin
               next_dec.op = insn_half[`F_SEL] ? OP_SRL : OP_SLL;
               next_dec.rd = MAP3[insn_half[`F_A3]];
               next_dec.rs = MAP3[insn_half[`F_B3]];
               next_dec.use_imm = 1'b1;
               next_dec.imm = (insn_half[`F_C3] == 3'h0) ? `SA_ZERO
                                                          : 32'(insn_half[`F_C3]);
            end
            `MJ_P16C:
            begin
               if (insn_half[`F_LOG] == 2'h0)
               begin
                  next_dec.rd = MAP3[insn_half[`F_A3]];
                  next_dec.rs = MAP3[insn_half[`F_B3]];
                  next_dec.rt = next_dec.rd;
                  case (insn_half[`F_I4])
                     `MN_NOT:
                     begin
                        next_dec.op = OP_NOR;
                        next_dec.rt = `R_ZERO;
                     end
                     `MN_XOR: next_dec.op = OP_XOR;
                     `MN_AND: next_dec.op = OP_AND;
                     `MN_OR:  next_dec.op = OP_OR;
                     default: next_dec.op = OP_RSVD;
                  endcase
               end
               else if (insn_half[`F_M6] == `MN_BRK ||
                        insn_half[`F_M6] == `MN_DBG)
               begin
                  next_dec.op = (insn_half[`F_M6] == `MN_BRK) ? OP_BRK
                                                              : OP_DBRK;
                  next_dec.imm = 32'(insn_half[`F_C4]);
               end
               else
               begin
                  next_dec.rs = insn_half[`F_A5];
                  case (insn_half[`F_B5])
                     `MN_JR:
                     begin
                        next_dec.op = OP_JR;
                        next_dec.has_slot = 1'b1;
                     end
                     `MN_JRC: next_dec.op = OP_JR;
                     `MN_JALR, `MN_JALRS:
                     begin
                        next_dec.op = OP_JR;
                        next_dec.link = 1'b1;
                        next_dec.rd = `R_RA;
                        next_dec.has_slot = 1'b1;
                        next_dec.short_slot = (insn_half[`F_B5] == `MN_JALRS);
                     end
                     `MN_MFHI, `MN_MFLO:
                     begin
                        next_dec.op = (insn_half[`F_B5] == `MN_MFHI) ? OP_MFHI
                                                                     : OP_MFLO;
                        next_dec.rd = insn_half[`F_A5];
                        next_dec.rs = `R_ZERO;
                     end
                     `MN_POP:
                     begin
                        next_dec.op = OP_JR;
                        next_dec.rs = `R_RA;
                        next_dec.rd = `R_SP;
                        next_dec.has_slot = 1'b1;
                        next_dec.imm = 32'(insn_half[`F_A5]) << `SH_W;
                     end
                     default: next_dec.op = OP_RSVD;
                  endcase
               end
            end
            `MJ_P16D:
            begin
               next_dec.op = OP_ADD;
               next_dec.use_imm = 1'b1;
               if (insn_half[`F_SEL])
               begin
                  next_dec.rd = `R_SP;
                  next_dec.rs = `R_SP;
                  next_dec.imm = 32'(adj) << `SH_W;
               end
               else
               begin
                  next_dec.rd = insn_half[`F_A5];
                  next_dec.rs = insn_half[`F_A5];
                  next_dec.imm = 32'($signed(insn_half[`F_I4H]));
               end
            end
            `MJ_P16E:
            begin
               next_dec.op = OP_ADD;
               next_dec.use_imm = 1'b1;
               next_dec.rd = MAP3[insn_half[`F_A3]];
               if (insn_half[`F_SEL])
               begin
                  next_dec.rs = `R_SP;
                  next_dec.imm = 32'(insn_half[`F_I6]) << `SH_W;
               end
               else
               begin
                  next_dec.rs = MAP3[insn_half[`F_B3]];
                  next_dec.imm = R2_IMM[insn_half[`F_C3]];
               end
            end
            `MJ_ANDI:
            begin
               next_dec.op = OP_AND;
               next_dec.use_imm = 1'b1;
               next_dec.rd = MAP3[insn_half[`F_A3]];
               next_dec.rs = MAP3[insn_half[`F_B3]];
               next_dec.imm = 32'(AND_MASK[insn_half[`F_I4]]);
            end
            `MJ_LI:
            begin
               next_dec.op = OP_ADD;
               next_dec.use_imm = 1'b1;
               next_dec.rd = MAP3[insn_half[`F_A3]];
               next_dec.imm = (insn_half[`F_I7] == `LI_NEG) ? '1
                                                            : 32'(insn_half[`F_I7]);
            end
            `MJ_LBU, `MJ_LHU, `MJ_LW, `MJ_SB, `MJ_SH, `MJ_SW:
            begin
               next_dec.use_imm = 1'b1;
               next_dec.rs = MAP3[insn_half[`F_B3]];
               next_dec.op = insn_half[`F_ST] ? OP_STORE : OP_LOAD;
               if (insn_half[`F_ST])
                  next_dec.rt = MAP3Z[insn_half[`F_A3]];
               else
                  next_dec.rd = MAP3[insn_half[`F_A3]];
               case (insn_half[`F_MAJ])
                  `MJ_LBU:
                  begin
                     next_dec.size = SZ_B;
                     next_dec.imm = (insn_half[`F_I4] == `LBU_NEG) ? '1
                                                                   : 32'(insn_half[`F_I4]);
                  end
                  `MJ_SB:
                  begin
                     next_dec.size = SZ_B;
                     next_dec.imm = 32'(insn_half[`F_I4]);
                  end
                  `MJ_LHU, `MJ_SH:
                  begin
                     next_dec.size = SZ_H;
                     next_dec.imm = 32'(insn_half[`F_I4]) << `SH_BR;
                  end
                  default: next_dec.imm = 32'(insn_half[`F_I4]) << `SH_W;
               endcase
            end
            `MJ_STACK_WORD_LOAD, `MJ_STACK_WORD_STORE:
            begin
               next_dec.use_imm = 1'b1;
               next_dec.rs = `R_SP;
               next_dec.imm = 32'(insn_half[`F_B5]) << `SH_W;
               if (insn_half[`F_MAJ] == `MJ_STACK_WORD_STORE)
               begin
                  next_dec.op = OP_STORE;
                  next_dec.rt = insn_half[`F_A5];
               end
               else
               begin
                  next_dec.op = OP_LOAD;
                  next_dec.rd = insn_half[`F_A5];
               end
            end
            `MJ_LWGP:
            begin
               next_dec.op = OP_LOAD;
               next_dec.use_imm = 1'b1;
               next_dec.rd = MAP3[insn_half[`F_A3]];
               next_dec.rs = `R_GP;
               next_dec.imm = 32'($signed(insn_half[`F_I7])) << `SH_W;
            end
            `MJ_B:
            begin
               next_dec.op = OP_B;
               next_dec.has_slot = 1'b1;
               next_dec.imm = 32'($signed(insn_half[`F_I10])) << `SH_BR;
            end
            `MJ_BEQZ, `MJ_BNEZ:
            begin
               next_dec.op = (insn_half[`F_MAJ] == `MJ_BEQZ) ? OP_BEQ : OP_BNE;
               next_dec.has_slot = 1'b1;
               next_dec.rs = MAP3[insn_half[`F_A3]];
               next_dec.rt = `R_ZERO;
               next_dec.imm = 32'($signed(insn_half[`F_I7])) << `SH_BR;
            end
            default: next_dec.op = OP_RSVD;
         endcase
      end
   end
   // ----------------------------------------
   // output stage
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         dec <= '0;
         dec_valid <= 1'b0;
      end
      else
      begin
         dec_valid <= take;
         if (take)
            dec <= next_dec;
      end
   end
   // ----------------------------------------
   // apb registers
   // ----------------------------------------
   // zero wait states keep fetch throughput; read data captured in setup
   assign pready  = 1'b1;
   assign mapped  = (paddr == `CCD_CTRL) || (paddr == `CCD_STAT);
   assign pslverr = psel && penable && !mapped;
   assign wr_acc  = psel && penable && pwrite && mapped;

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         ctrl_en <= `CCD_CTRL_RST;
      else if (wr_acc && (paddr == `CCD_CTRL))
         ctrl_en <= pwdata[0];
   end

   // a reserved hit in the clearing cycle still counts
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         rsvd_cnt <= '0;
         last_op  <= OP_ADD;
      end
      else
      begin
         if (take)
            last_op <= next_dec.op;
         if (take && next_dec.op == OP_RSVD)
            rsvd_cnt <= (wr_acc && paddr == `CCD_STAT) ? 16'h0001 : rsvd_cnt + 16'h0001;
         else if (wr_acc && paddr == `CCD_STAT)
            rsvd_cnt <= '0;
      end
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         prdata <= '0;
      else if (psel && !penable)
         prdata <= (paddr == `CCD_CTRL) ? {31'h0, ctrl_en} :
                   (paddr == `CCD_STAT) ? {11'h0, last_op, rsvd_cnt} : 32'h0;
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_take(logic [5:0] m);
      take && insn_half[`F_MAJ] == m;
   endsequence
   property p_copy;
      s_take(`MJ_MOVE) |=> dec_valid && dec.op == OP_ADD
         && dec.rd == $past(insn_half[`F_A5]) && dec.rs == $past(insn_half[`F_B5]);
   endproperty
   a_copy: assert property (p_copy) else $error("copy fields wrong");
   property p_nop;
      s_take(`MJ_MOVE) and (insn_half[`F_I10] == 10'h000)
         |=> dec.op == OP_ADD && dec.rd == `R_ZERO && dec.rs == `R_ZERO;
   endproperty
   a_nop: assert property (p_nop) else $error("no-op not zero copy");
   property p_stack_word_store;
      s_take(`MJ_STACK_WORD_STORE) |=> dec.op == OP_STORE && dec.rs == `R_SP
         && dec.imm == (32'($past(insn_half[`F_B5])) << `SH_W);
   endproperty
   a_stack_word_store: assert property (p_stack_word_store) else $error("stack store offset");
   property p_adj;
      s_take(`MJ_P16D) and (insn_half[`F_I9] == 9'h000) and insn_half[`F_SEL]
         |=> dec.rd == `R_SP && dec.imm == 32'h00000400;
   endproperty
   a_adj: assert property (p_adj) else $error("stack adjust value");
   property p_r2;
      s_take(`MJ_P16E) and !insn_half[`F_SEL] and (insn_half[`F_C3] == 3'h0)
         |=> dec.imm == 32'hFFFFFFFF;
   endproperty
   a_r2: assert property (p_r2) else $error("two-reg add constant");
   property p_b16;
      s_take(`MJ_B) |=> dec.op == OP_B
         && dec.imm == (32'($signed($past(insn_half[`F_I10]))) << `SH_BR);
   endproperty
   a_b16: assert property (p_b16) else $error("branch offset");
   property p_call;
      s_take(`MJ_P16C) and (insn_half[`F_B5] == `MN_JALR) and (insn_half[`F_LOG] != 2'h0)
         |=> dec.link && dec.has_slot && !dec.short_slot;
   endproperty
   a_call: assert property (p_call) else $error("long slot call");
   property p_len;
      take and !is16 |=> dec.is_long && dec.op == OP_LONG;
   endproperty
   a_len: assert property (p_len) else $error("length from major");
   property p_rsvd;
      s_take(`MJ_P16C) and (insn_half[`F_I4] == 4'h4) and !wr_acc
         |=> dec.op == OP_RSVD && rsvd_cnt == $past(rsvd_cnt) + 16'h0001;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved not flagged");

endmodule // ccd_decoder

// [rtl/ccd_pkg.sv]
// ccd_pkg.sv: types of the compact instruction decoder
package ccd_pkg;
   typedef enum logic [4:0]
   {
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_NOR, OP_SLL, OP_SRL,
      OP_LOAD, OP_STORE, OP_B, OP_BEQ, OP_BNE, OP_JR, OP_MFHI, OP_MFLO,
      OP_BRK, OP_DBRK, OP_RSVD, OP_LONG
   } ccd_op_t;
   typedef enum logic [1:0] {SZ_B, SZ_H, SZ_W} ccd_size_t;
   typedef struct packed {
      ccd_op_t     op;
      logic [4:0]  rd;
      logic [4:0]  rs;
      logic [4:0]  rt;
      logic [31:0] imm;
      logic        use_imm;
      ccd_size_t   size;
      logic        link;
      logic        has_slot;
      logic        short_slot;
      logic        is_long;
   } ccd_dec_t;
endpackage

// [tb/ccd_fetch_model.sv]
// ccd_fetch_model.sv: fetch stage model offering halfwords to the decoder
`timescale 1ns/10ps
module ccd_fetch_model
(
   // clock
   input  wire logic        core_clk,
   // handshake
   input  wire logic        insn_ready,
   output logic             insn_valid,
   output logic [15:0]      insn_half
);
   initial
   begin
      insn_valid = 1'b0;
      insn_half  = 16'h0000;
   end
   // ----------------------------------------
   // offer one halfword, optionally after a stall
   // ----------------------------------------
   // the bus shows the inverse once released so a stale value never passes
   task automatic offer(input logic [15:0] h, input int stall);
      repeat (stall + 1) @(posedge core_clk);
      insn_valid <= 1'b1;
      insn_half  <= h;
      @(posedge core_clk);
      while (insn_ready !== 1'b1) @(posedge core_clk);
      insn_valid <= 1'b0;
      insn_half  <= ~h;
   endtask
endmodule // ccd_fetch_model

// [tb/testbench.sv]
// testbench.sv: self-checking bench of the compact decoder
`timescale 1ns/10ps
module testbench
   import ccd_pkg::*;
;
   localparam logic [4:0]  z5  = 5'h00;
   localparam logic [31:0] z32 = 32'h00000000;
   logic        core_clk = 1'b0;
   logic        reset    = 1'b1;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        insn_valid;
   logic [15:0] insn_half;
   logic        insn_ready;
   ccd_dec_t    dec;
   logic        dec_valid;
   int          fails = 0;
   int          checks_done = 0;
   logic [31:0] seed = 32'hE64D8AD8;
   logic [31:0] and_tbl [16] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h7, 32'h8, 32'hF, 32'h10,
      32'h1F, 32'h20, 32'h3F, 32'h40, 32'h80, 32'hFF, 32'h8000, 32'hFFFF};
   logic [31:0] add_tbl [8] = '{32'hFFFFFFFF, 32'h1, 32'h4, 32'h8, 32'hC, 32'h10, 32'h14, 32'h18};
   logic [5:0]  ld_maj [3] = '{6'h02, 6'h0A, 6'h1A};
   logic [5:0]  st_maj [3] = '{6'h22, 6'h2A, 6'h3A};
   logic [4:0]  jmp_mn [4] = '{5'h05, 5'h07, 5'h0D, 5'h0F};
   logic [3:0]  jmp_fl [4] = '{4'h4, 4'h0, 4'hC, 4'hE};
   ccd_op_t     lg_op [4] = '{OP_NOR, OP_XOR, OP_AND, OP_OR};

   always #50 core_clk = ~core_clk;

   ccd_decoder i_ccd_decoder (.core_clk(core_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .insn_valid(insn_valid), .insn_half(insn_half),
      .insn_ready(insn_ready), .dec(dec), .dec_valid(dec_valid));
   ccd_fetch_model i_ccd_fetch_model (.core_clk(core_clk), .insn_ready(insn_ready),
      .insn_valid(insn_valid), .insn_half(insn_half));

   // ----------------------------------------
   // expectation helpers and drivers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [4:0] rm(input logic [2:0] c);
      return (c < 3'h2) ? {4'h8, c[0]} : {2'h0, c};
   endfunction
   function automatic logic [4:0] sm(input logic [2:0] c);
      return (c == 3'h0) ? z5 : rm(c);
   endfunction
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // setup and access phases; pready is sampled at the edge where data is taken
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // mask bits: op rd rs rt imm slot-flags long
   task automatic dx(input logic [15:0] h, input ccd_op_t op, input logic [4:0] rd, rs, rt,
                     input logic [31:0] imm, input logic [3:0] fl, input logic [6:0] m);
      logic [55:0] mk;
      mk = {{5{m[6]}}, {5{m[5]}}, {5{m[4]}}, {5{m[3]}}, {32{m[2]}}, {3{m[1]}}, m[0]};
      i_ccd_fetch_model.offer(h, int'(seed[1:0]));
      #1;
      chk("dec_valid", 64'(dec_valid), 64'h1);
      chk($sformatf("dec %h", h), 64'({dec.op, dec.rd, dec.rs, dec.rt, dec.imm, dec.link,
          dec.has_slot, dec.short_slot, dec.is_long} & mk), 64'({op, rd, rs, rt, imm, fl} & mk));
      @(posedge core_clk);
      #1;
      chk("dec_valid one cycle", 64'(dec_valid), 64'h0);
   endtask

   initial
   begin
      #1000000;
      fails++;
      stop_test;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      logic [31:0] d;
      logic        e;
      logic [4:0]  a5, b5;
      logic [2:0]  a3, b3;
      logic [8:0]  e9;
      logic [6:0]  i7;
      int          v;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      apb(1'b0, 12'h000, z32, d, e);
      chk("ctrl reset", 64'(d[0]), 64'h1);
      chk("pready", 64'(pready), 64'h1);
      apb(1'b0, 12'h008, z32, d, e);
      chk("unmapped", 64'({e, d}), 64'h100000000);
      apb(1'b1, 12'h000, z32, d, e);
      #1;
      chk("ready off", 64'(insn_ready), 64'h0);
      apb(1'b1, 12'h000, 32'h1, d, e);
      dx(16'h0C00, OP_ADD, z5, z5, z5, z32, 4'h0, 7'h70);
      for (int k = 0; k < 16; k++)
      begin
         seed = lfsr(seed);
         a5 = seed[4:0];
         b5 = seed[9:5];
         a3 = seed[12:10];
         b3 = seed[15:13];
         e9 = {k[1], {7{k[0]}}, k[2]};
         v = e9[8] ? int'(e9) - 512 : int'(e9);
         v = (v == 0 || v == 1) ? v + 256 : (v == -1 || v == -2) ? v - 256 : v;
         i7 = (k == 15) ? 7'h7F : {1'h0, seed[21:16]};
         dx({6'h03, a5, b5}, OP_ADD, a5, b5, z5, z32, 4'h0, 7'h70);
         dx({6'h13, a5, k[3:0], 1'h0}, OP_ADD, a5, a5, z5, {{28{k[3]}}, k[3:0]}, 4'h0, 7'h74);
         dx({6'h13, e9, 1'h1}, OP_ADD, 5'h1D, 5'h1D, z5, 32'(v * 4), 4'h0, 7'h74);
         dx({6'h1B, a3, b3, k[2:0], 1'h0}, OP_ADD, rm(a3), rm(b3), z5, add_tbl[k[2:0]], 4'h0,
            7'h74);
         dx({6'h1B, a3, seed[21:16], 1'h1}, OP_ADD, rm(a3), 5'h1D, z5,
            {24'h0, seed[21:16], 2'h0}, 4'h0, 7'h74);
         dx({6'h01, a3, b3, 4'h1}, OP_SUB, rm(a3), z5, rm(b3), z32, 4'h0, 7'h78);
         dx({6'h09, a3, b3, k[2:0], k[3]}, k[3] ? OP_SRL : OP_SLL, rm(a3), rm(b3), z5,
            (k[2:0] == 3'h0) ? 32'h8 : 32'(k[2:0]), 4'h0, 7'h74);
         dx({6'h11, a3, b3, 2'h0, k[1:0]}, lg_op[k[1:0]], rm(a3), rm(b3), z5, z32, 4'h0,
            7'h70);
         for (int j = 0; j < 3; j++)
         begin
            dx({ld_maj[j], a3, b3, k[3:0]}, OP_LOAD, rm(a3), rm(b3), z5,
               (j == 0 && k == 15) ? 32'hFFFFFFFF : 32'(k << j), 4'h0, 7'h74);
            chk("load size", 64'(dec.size), 64'(j));
            dx({st_maj[j], a3, b3, k[3:0]}, OP_STORE, z5, rm(b3), sm(a3), 32'(k << j), 4'h0,
               7'h5C);
            chk("store size", 64'(dec.size), 64'(j));
         end
         dx({6'h12, a5, b5}, OP_LOAD, a5, 5'h1D, z5, {25'h0, b5, 2'h0}, 4'h0, 7'h74);
         dx({6'h32, a5, b5}, OP_STORE, z5, 5'h1D, a5, {25'h0, b5, 2'h0}, 4'h0, 7'h5C);
         dx({6'h19, a3, i7}, OP_LOAD, rm(a3), 5'h1C, z5, {{23{i7[6]}}, i7, 2'h0}, 4'h0,
            7'h74);
         dx({6'h33, seed[25:16]}, OP_B, z5, z5, z5, {{21{seed[25]}}, seed[25:16], 1'h0}, 4'h0,
            7'h44);
         dx({6'h23, a3, seed[22:16]}, OP_BEQ, z5, rm(a3), z5,
            {{24{seed[22]}}, seed[22:16], 1'h0}, 4'h0, 7'h54);
         dx({6'h2B, a3, seed[22:16]}, OP_BNE, z5, rm(a3), z5,
            {{24{seed[22]}}, seed[22:16], 1'h0}, 4'h0, 7'h54);
         for (int j = 0; j < 4; j++)
            dx({6'h11, a5, jmp_mn[j]}, OP_JR, 5'h1F, a5, z5, z32, jmp_fl[j],
               j[1] ? 7'h72 : 7'h52);
         dx({6'h11, a5, 5'h0E}, OP_MFHI, a5, z5, z5, z32, 4'h0, 7'h60);
         dx({6'h11, a5, 5'h0C}, OP_MFLO, a5, z5, z5, z32, 4'h0, 7'h60);
         dx({6'h11, b5, 5'h0B}, OP_JR, 5'h1D, 5'h1F, z5, {25'h0, b5, 2'h0}, 4'h0, 7'h74);
         dx({6'h11, k[3:0], 6'h1B}, OP_BRK, z5, z5, z5, 32'(k), 4'h0, 7'h44);
         dx({6'h11, k[3:0], 6'h3B}, OP_DBRK, z5, z5, z5, 32'(k), 4'h0, 7'h44);
         dx({6'h0B, a3, b3, k[3:0]}, OP_AND, z5, z5, z5, and_tbl[k], 4'h0, 7'h44);
         dx({6'h3B, a3, i7}, OP_ADD, z5, z5, z5, (k == 15) ? 32'hFFFFFFFF : {25'h0, i7}, 4'h0,
            7'h04);
      end
      for (int mj = 0; mj < 64; mj++)
         dx({mj[5:0], seed[9:0]}, OP_LONG, z5, z5, z5, z32,
            {3'h0, !(mj[2:0] >= 3'h1 && mj[2:0] <= 3'h3)}, 7'h01);
      apb(1'b1, 12'h004, z32, d, e);
      dx({6'h11, a5, 5'h09}, OP_RSVD, z5, z5, z5, z32, 4'h0, 7'h40);
      dx({6'h11, b5, 5'h14}, OP_RSVD, z5, z5, z5, z32, 4'h0, 7'h40);
      apb(1'b0, 12'h004, z32, d, e);
      chk("stat", 64'(d[20:0]), 64'({OP_RSVD, 16'h0002}));
      stop_test;
   end
endmodule // testbench
